// >>> core/ppom_pin.sv
package ppom_pkg;
  localparam int unsigned PIN_COUNT = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] DIR_OFS = 8'h00;
  localparam logic [7:0] OUT_OFS = 8'h04;
  localparam logic [7:0] PIN_OFS = 8'h08;
  localparam logic [7:0] CTRL_OFS = 8'h0c;
  localparam logic [7:0] PADOE_OFS = 8'h10;
  localparam logic [7:0] PULLUP_OFS = 8'h14;
  localparam logic [7:0] DINEN_OFS = 8'h18;
  // control register field
  localparam int unsigned CTRL_PUD_BIT = 0;
  localparam logic CTRL_PUD_RST = 1'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [23:0] PAD_ZERO = 24'h00_0000;
  localparam logic [30:0] CTRL_ZERO = 31'h0000_0000;

  typedef struct packed {
    logic dir;
    logic out;
    logic sync_a;
    logic sync_b;
    logic tap;
    logic oe;
    logic drv;
    logic pu;
    logic die;
  } ppom_pin_state_t;

  localparam ppom_pin_state_t PIN_RST = '{
    dir: 1'h0, out: 1'h0, sync_a: 1'h0, sync_b: 1'h0, tap: 1'h0,
    oe: 1'h0, drv: 1'h0, pu: 1'h0, die: 1'h1};

  typedef struct packed {
    logic ready;
    logic err;
    logic global_pullup_disable;
    logic [31:0] rdata;
  } ppom_bus_state_t;
endpackage : ppom_pkg

`timescale 1ns/1ps
`default_nettype none

module ppom_pin (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic write_dir_reg_strobe_i,
  input wire logic write_out_reg_strobe_i,
  input wire logic write_in_reg_strobe_i,
  input wire logic wbit_i,
  input wire logic global_pullup_disable_i,
  input wire logic sleep_i,
  input wire logic pad_in_i,
  input wire logic pullup_ovr_en_i,
  input wire logic pullup_ovr_val_i,
  input wire logic dir_ovr_en_i,
  input wire logic dir_ovr_val_i,
  input wire logic outval_ovr_en_i,
  input wire logic outval_ovr_val_i,
  input wire logic toggle_ovr_en_i,
  input wire logic din_enable_ovr_en_i,
  input wire logic din_enable_ovr_val_i,
  output logic pin_direction_bit_o,
  output logic pin_output_bit_o,
  output logic pin_input_bit_o,
  output logic pad_oe_o,
  output logic pad_out_o,
  output logic pullup_en_o,
  output logic din_enable_o,
  output logic altfn_raw_input_o
);
  ppom_pkg::ppom_pin_state_t st;
  ppom_pkg::ppom_pin_state_t next_st;

  // ----------------------------------------
  // per-pin next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    if (write_dir_reg_strobe_i) begin
      next_st.dir = wbit_i;
    end
    // plain write beats a toggle in the same cycle
    if (write_out_reg_strobe_i) begin
      next_st.out = wbit_i;
    end else if ((write_in_reg_strobe_i && wbit_i) || toggle_ovr_en_i) begin
      next_st.out = ~st.out;
    end
    // pad_in is the clamped schmitt output; din_enable_o does the clamp
    next_st.sync_a = pad_in_i;
    next_st.sync_b = st.sync_a;
    next_st.tap = pad_in_i;
    if (dir_ovr_en_i) begin
      next_st.oe = dir_ovr_val_i;
    end else begin
      next_st.oe = st.dir;
    end
    if (outval_ovr_en_i) begin
      next_st.drv = outval_ovr_val_i;
    end else begin
      next_st.drv = st.out;
    end
    if (pullup_ovr_en_i) begin
      next_st.pu = pullup_ovr_val_i;
    end else begin
      next_st.pu = ~st.dir & st.out & ~global_pullup_disable_i;
    end
    if (din_enable_ovr_en_i) begin
      next_st.die = din_enable_ovr_val_i;
    end else begin
      next_st.die = ~sleep_i;
    end
  end

  // reset leaves the driver and pull-up off
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st <= ppom_pkg::PIN_RST;
    end else begin
      st <= next_st;
    end
  end

  assign pin_direction_bit_o = st.dir;
  assign pin_output_bit_o = st.out;
  assign pin_input_bit_o = st.sync_b;
  assign pad_oe_o = st.oe;
  assign pad_out_o = st.drv;
  assign pullup_en_o = st.pu;
  assign din_enable_o = st.die;
  assign altfn_raw_input_o = st.tap;
endmodule : ppom_pin

`default_nettype wire

// >>> core/ppom_port.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - pull-up override enable selects pull-up override value
// - otherwise pull-up when input, out high, enabled
// - direction override enable selects driver enable value
// - otherwise driver enable follows direction bit
// - value override enable selects driven level
// - otherwise driven level follows output bit
// - toggle override enable inverts output bit
// - input-enable override sets digital input enable
// - otherwise input enable follows sleep state
// - raw peripheral input taken before synchronizer
// - analog pad path bypasses all digital logic
// - strobes per port, globals shared, overrides per pin
// - sleep clamps input unless alternate function overrides
// - pins tri-stated while reset is asserted
module ppom_port (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sleep_i,
  input wire logic [7:0] pad_in_i,
  input wire logic [7:0] pullup_ovr_en_i,
  input wire logic [7:0] pullup_ovr_val_i,
  input wire logic [7:0] dir_ovr_en_i,
  input wire logic [7:0] dir_ovr_val_i,
  input wire logic [7:0] outval_ovr_en_i,
  input wire logic [7:0] outval_ovr_val_i,
  input wire logic [7:0] toggle_ovr_en_i,
  input wire logic [7:0] din_enable_ovr_en_i,
  input wire logic [7:0] din_enable_ovr_val_i,
  output logic [7:0] pad_out_o,
  output logic [7:0] pad_oe_o,
  output logic [7:0] pullup_en_o,
  output logic [7:0] din_enable_o,
  output logic [7:0] altfn_raw_input_o,
  output logic global_pullup_disable_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  ppom_pkg::ppom_bus_state_t st;
  ppom_pkg::ppom_bus_state_t next_st;

  logic [7:0] pin_direction_bit;
  logic [7:0] pin_output_bit;
  logic [7:0] pin_input_bit;

  logic access;
  logic commit;
  logic capture;
  logic sel_dir;
  logic sel_out;
  logic sel_pin;
  logic sel_ctrl;
  logic sel_padoe;
  logic sel_pullup;
  logic sel_dinen;
  logic hit;

  logic write_dir_reg_strobe;
  logic write_out_reg_strobe;
  logic write_in_reg_strobe;
  logic write_ctrl_strobe;
  logic read_dir_reg_strobe;
  logic read_out_reg_strobe;
  logic read_pin_strobe;
  logic read_ctrl_strobe;
  logic read_padoe_strobe;
  logic read_pullup_strobe;
  logic read_dinen_strobe;
  logic [31:0] rd_mux;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // only the exact aligned word matches; anything else is unmapped
  assign sel_dir = (paddr_i == ppom_pkg::DIR_OFS);
  assign sel_out = (paddr_i == ppom_pkg::OUT_OFS);
  assign sel_pin = (paddr_i == ppom_pkg::PIN_OFS);
  assign sel_ctrl = (paddr_i == ppom_pkg::CTRL_OFS);
  assign sel_padoe = (paddr_i == ppom_pkg::PADOE_OFS);
  assign sel_pullup = (paddr_i == ppom_pkg::PULLUP_OFS);
  assign sel_dinen = (paddr_i == ppom_pkg::DINEN_OFS);

  assign hit = sel_dir | sel_out | sel_pin | sel_ctrl
             | sel_padoe | sel_pullup | sel_dinen;

  // ----------------------------------------
  // bus phases
  // ----------------------------------------
  // access phase always waits one cycle; pready is a flop
  assign access = psel_i & penable_i;
  assign commit = access & st.ready;
  assign capture = access & ~st.ready;

  // ----------------------------------------
  // shared strobes
  // ----------------------------------------
  // one write strobe each for DIR, OUT and PIN drives every pin of the port
  assign write_dir_reg_strobe = commit & pwrite_i & sel_dir;
  assign write_out_reg_strobe = commit & pwrite_i & sel_out;
  assign write_in_reg_strobe = commit & pwrite_i & sel_pin;
  assign write_ctrl_strobe = commit & pwrite_i & sel_ctrl;

  assign read_dir_reg_strobe = capture & ~pwrite_i & sel_dir;
  assign read_out_reg_strobe = capture & ~pwrite_i & sel_out;
  assign read_pin_strobe = capture & ~pwrite_i & sel_pin;
  assign read_ctrl_strobe = capture & ~pwrite_i & sel_ctrl;
  assign read_padoe_strobe = capture & ~pwrite_i & sel_padoe;
  assign read_pullup_strobe = capture & ~pwrite_i & sel_pullup;
  assign read_dinen_strobe = capture & ~pwrite_i & sel_dinen;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    rd_mux = ppom_pkg::RDATA_RST;
    if (read_dir_reg_strobe) begin
      rd_mux = {ppom_pkg::PAD_ZERO, pin_direction_bit};
    end
    if (read_out_reg_strobe) begin
      rd_mux = {ppom_pkg::PAD_ZERO, pin_output_bit};
    end
    if (read_pin_strobe) begin
      rd_mux = {ppom_pkg::PAD_ZERO, pin_input_bit};
    end
    if (read_ctrl_strobe) begin
      rd_mux = {ppom_pkg::CTRL_ZERO, st.global_pullup_disable};
    end
    if (read_padoe_strobe) begin
      rd_mux = {ppom_pkg::PAD_ZERO, pad_oe_o};
    end
    if (read_pullup_strobe) begin
      rd_mux = {ppom_pkg::PAD_ZERO, pullup_en_o};
    end
    if (read_dinen_strobe) begin
      rd_mux = {ppom_pkg::PAD_ZERO, din_enable_o};
    end
  end

  // ----------------------------------------
  // bus next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.ready = capture;
    if (capture) begin
      next_st.err = ~hit;
      next_st.rdata = rd_mux;
    end else begin
      next_st.err = 1'h0;
    end
    if (write_ctrl_strobe) begin
      next_st.global_pullup_disable = pwdata_i[ppom_pkg::CTRL_PUD_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st.ready <= 1'h0;
      st.err <= 1'h0;
      st.global_pullup_disable <= ppom_pkg::CTRL_PUD_RST;
      st.rdata <= ppom_pkg::RDATA_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata_o = st.rdata;
  assign pready_o = st.ready;
  assign pslverr_o = st.err;
  assign global_pullup_disable_o = st.global_pullup_disable;

  // ----------------------------------------
  // per-pin override logic
  // ----------------------------------------
  // overrides arrive from the owning peripherals, one per pin
  // the analog pad path never enters this block: no gate may sit on it
  for (genvar i = 0; i < ppom_pkg::PIN_COUNT; i++) begin : g_pin
    ppom_pin u_pin (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .write_dir_reg_strobe_i(write_dir_reg_strobe),
      .write_out_reg_strobe_i(write_out_reg_strobe),
      .write_in_reg_strobe_i(write_in_reg_strobe),
      .wbit_i(pwdata_i[i]),
      .global_pullup_disable_i(st.global_pullup_disable),
      .sleep_i(sleep_i),
      .pad_in_i(pad_in_i[i]),
      .pullup_ovr_en_i(pullup_ovr_en_i[i]),
      .pullup_ovr_val_i(pullup_ovr_val_i[i]),
      .dir_ovr_en_i(dir_ovr_en_i[i]),
      .dir_ovr_val_i(dir_ovr_val_i[i]),
      .outval_ovr_en_i(outval_ovr_en_i[i]),
      .outval_ovr_val_i(outval_ovr_val_i[i]),
      .toggle_ovr_en_i(toggle_ovr_en_i[i]),
      .din_enable_ovr_en_i(din_enable_ovr_en_i[i]),
      .din_enable_ovr_val_i(din_enable_ovr_val_i[i]),
      .pin_direction_bit_o(pin_direction_bit[i]),
      .pin_output_bit_o(pin_output_bit[i]),
      .pin_input_bit_o(pin_input_bit[i]),
      .pad_oe_o(pad_oe_o[i]),
      .pad_out_o(pad_out_o[i]),
      .pullup_en_o(pullup_en_o[i]),
      .din_enable_o(din_enable_o[i]),
      .altfn_raw_input_o(altfn_raw_input_o[i])
    );
  end

endmodule : ppom_port

`default_nettype wire

// >>> testbench/ppom_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module ppom_port_props (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic sleep_i,
  input wire logic [7:0] pad_in_i,
  input wire logic [7:0] pullup_ovr_en_i,
  input wire logic [7:0] pullup_ovr_val_i,
  input wire logic [7:0] dir_ovr_en_i,
  input wire logic [7:0] dir_ovr_val_i,
  input wire logic [7:0] outval_ovr_en_i,
  input wire logic [7:0] outval_ovr_val_i,
  input wire logic [7:0] din_enable_ovr_en_i,
  input wire logic [7:0] din_enable_ovr_val_i,
  input wire logic [7:0] pad_out_o,
  input wire logic [7:0] pad_oe_o,
  input wire logic [7:0] pullup_en_o,
  input wire logic [7:0] din_enable_o,
  input wire logic [7:0] altfn_raw_input_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  a_pu_ovr: assert property (
    1'b1 |=> ((pullup_en_o ^ $past(pullup_ovr_val_i)) & $past(pullup_ovr_en_i)) == 8'h00)
    else $error("pull-up ignores its override");
  a_dir_ovr: assert property (
    1'b1 |=> ((pad_oe_o ^ $past(dir_ovr_val_i)) & $past(dir_ovr_en_i)) == 8'h00)
    else $error("driver enable ignores its override");
  a_val_ovr: assert property (
    1'b1 |=> ((pad_out_o ^ $past(outval_ovr_val_i)) & $past(outval_ovr_en_i) & pad_oe_o) == 8'h00)
    else $error("driven level ignores its override");
  a_din_ovr: assert property (
    1'b1 |=> ((din_enable_o ^ $past(din_enable_ovr_val_i)) & $past(din_enable_ovr_en_i)) == 8'h00)
    else $error("input enable ignores its override");
  a_din_sleep: assert property (
    1'b1 |=> ((din_enable_o ^ {8{!$past(sleep_i)}}) & ~$past(din_enable_ovr_en_i)) == 8'h00)
    else $error("input enable does not follow sleep");
  a_raw_tap: assert property (1'b1 |=> altfn_raw_input_o == $past(pad_in_i))
    else $error("raw input tap late or wrong");
  a_reset_tri: assert property (disable iff (1'b0) srst_i |=> pad_oe_o == 8'h00)
    else $error("pins driven during reset");
  a_apb_answer: assert property (s_access |=> pready_o)
    else $error("transfer not answered in time");
endmodule : ppom_port_props
bind ppom_port ppom_port_props u_props (.*);
`default_nettype wire

// >>> testbench/ppom_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppom_periph_model (
  input wire logic mclk_i,
  input wire logic [7:0] pad_oe_i,
  input wire logic [7:0] pad_out_i,
  input wire logic [7:0] pullup_en_i,
  input wire logic [7:0] din_enable_i,
  input wire logic [7:0] raw_i,
  output logic [7:0] pad_in_o,
  output logic [7:0] pu_en_o,
  output logic [7:0] pu_val_o,
  output logic [7:0] dir_en_o,
  output logic [7:0] dir_val_o,
  output logic [7:0] ov_en_o,
  output logic [7:0] ov_val_o,
  output logic [7:0] tg_en_o,
  output logic [7:0] die_en_o,
  output logic [7:0] die_val_o
);
  logic [7:0] ext = 8'h00;
  logic [15:0] sync_q = 16'h0000;
  // pad clamps to ground when input is off; floating pins show ext
  assign pad_in_o = din_enable_i & ((pad_oe_i & pad_out_i) | (~pad_oe_i & (pullup_en_i | ext)));
  initial {pu_en_o, pu_val_o, dir_en_o, dir_val_o, ov_en_o, ov_val_o, tg_en_o, die_en_o, die_val_o} = 72'h0;
  always @(posedge mclk_i) sync_q <= {sync_q[7:0], raw_i};
  task automatic drive(input logic [71:0] v);
    @(posedge mclk_i);
    {pu_en_o, pu_val_o, dir_en_o, dir_val_o, ov_en_o, ov_val_o, tg_en_o, die_en_o, die_val_o} <= v;
  endtask : drive
endmodule : ppom_periph_model
`default_nettype wire

// >>> testbench/ppom_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ppom_port_tb_top;
  logic mclk_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, sleep_i = 0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, global_pullup_disable_o, er;
  logic [7:0] pad_out_o, pad_oe_o, pullup_en_o, din_enable_o, altfn_raw_input_o, pad_in_i;
  logic [7:0] pullup_ovr_en_i, pullup_ovr_val_i, dir_ovr_en_i, dir_ovr_val_i, toggle_ovr_en_i;
  logic [7:0] outval_ovr_en_i, outval_ovr_val_i, din_enable_ovr_en_i, din_enable_ovr_val_i;
  int mismatches = 0, check_count = 0;
  ppom_port DUT (.*);
  ppom_periph_model PER (.mclk_i(mclk_i), .pad_oe_i(pad_oe_o), .pad_out_i(pad_out_o),
    .pullup_en_i(pullup_en_o), .din_enable_i(din_enable_o), .raw_i(altfn_raw_input_o),
    .pad_in_o(pad_in_i), .pu_en_o(pullup_ovr_en_i), .pu_val_o(pullup_ovr_val_i),
    .dir_en_o(dir_ovr_en_i), .dir_val_o(dir_ovr_val_i), .ov_en_o(outval_ovr_en_i),
    .ov_val_o(outval_ovr_val_i), .tg_en_o(toggle_ovr_en_i), .die_en_o(din_enable_ovr_en_i),
    .die_val_o(din_enable_ovr_val_i));
  initial forever #5 mclk_i = ~mclk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick
  // waits on pready however long the slave takes; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, 1'b0, w, a, d};
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask : apb
  task automatic t_reset;
    apb(1, ppom_pkg::DIR_OFS, 32'hff);
    tick(2);
    chk(pad_oe_o, 8'hff);
    srst_i <= 1'b1;
    tick(2);
    chk(pad_oe_o, 8'h00);
    srst_i <= 1'b0;
    apb(0, ppom_pkg::DIR_OFS, 32'h0);
    chk(rd, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_plain;
    PER.ext <= 8'ha0;
    apb(1, ppom_pkg::DIR_OFS, 32'h0f);
    apb(1, ppom_pkg::OUT_OFS, 32'h33);
    tick(2);
    chk(pad_oe_o, 8'h0f);
    chk(pad_out_o & pad_oe_o, 8'h03);
    chk(pullup_en_o, 8'h30);
    apb(1, ppom_pkg::CTRL_OFS, 32'h1);
    tick(3);
    chk(global_pullup_disable_o, 1'b1);
    chk(pullup_en_o, 8'h00);
    chk(altfn_raw_input_o, 8'ha3);
    apb(0, ppom_pkg::PIN_OFS, 32'h0);
    chk(rd, 32'ha3);
    chk(PER.sync_q[15:8], 8'ha3);
    apb(0, 8'h40, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    $display("t_plain done");
  endtask : t_plain
  task automatic t_ovr;
    PER.drive({8'hff, 8'h5a, 8'hff, 8'hc3, 8'hff, 8'h96, 8'h00, 8'hff, 8'h0f});
    sleep_i <= 1'b1;
    tick(2);
    chk(pullup_en_o, 8'h5a);
    chk(pad_oe_o, 8'hc3);
    chk(pad_out_o & pad_oe_o, 8'h82);
    chk(din_enable_o, 8'h0f);
    PER.drive(72'h0);
    tick(2);
    chk(din_enable_o, 8'h00);
    sleep_i <= 1'b0;
    tick(2);
    chk(din_enable_o, 8'hff);
    $display("t_ovr done");
  endtask : t_ovr
  task automatic t_toggle;
    PER.drive(72'h01_0000);
    PER.drive(72'h0);
    apb(0, ppom_pkg::OUT_OFS, 32'h0);
    chk(rd, 32'h32);
    apb(1, ppom_pkg::PIN_OFS, 32'h04);
    apb(0, ppom_pkg::OUT_OFS, 32'h0);
    chk(rd, 32'h36);
    $display("t_toggle done");
  endtask : t_toggle
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  initial begin
    #200000;
    mismatches++;
    conclude();
  end
  initial begin
    tick(20);
    srst_i <= 1'b0;
    t_reset();
    t_plain();
    t_ovr();
    t_toggle();
    conclude();
  end
endmodule : ppom_port_tb_top
`default_nettype wire
